//--- include/fpc_pkg.sv
// Constants shared by the fast position capture unit.
// Assumes one 250 MHz system clock and a 16-bit parameter address space.
package fpc_pkg;

  // Parameter addresses
  localparam logic [15:0] ADDR_A_EDGE = 16'h0a04;
  localparam logic [15:0] ADDR_B_EDGE = 16'h0a06;
  localparam logic [15:0] ADDR_A_ARM = 16'h0a08;
  localparam logic [15:0] ADDR_B_ARM = 16'h0a0a;
  localparam logic [15:0] ADDR_A_POS = 16'h0a0c;
  localparam logic [15:0] ADDR_B_POS = 16'h0a0e;
  localparam logic [15:0] ADDR_A_TALLY = 16'h0a10;
  localparam logic [15:0] ADDR_B_TALLY = 16'h0a12;

  // Arm command codes, in order stop, once, continuous
  typedef enum logic [1:0] {ARM_STOP, ARM_ONCE, ARM_CONT} fpc_arm_t;
  localparam logic [15:0] ARM_MAX = 16'h0002;

  // Edge select encoding and reset values
  localparam logic EDGE_FALL = 1'h0;
  localparam logic EDGE_RISE = 1'h1;
  localparam logic EDGE_RESET = EDGE_FALL;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;
  localparam logic [15:0] TALLY_RESET = 16'h0000;

  // Input conditioning time, rounded up to whole clock cycles
  localparam int FILTER_TIME_NS = 10000;
  localparam int CLK_FREQ_MHZ = 250;
  localparam int FILTER_CYCLES = (FILTER_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

endpackage

//--- logic/fpc_channel.sv
// One capture channel: synchroniser, input filter, arm state and position latch.
// Assumes the capture input is asynchronous and the position is valid every cycle.
`timescale 1ns/10ps
module fpc_channel #(
  parameter int FILTER_CYCLES = fpc_pkg::FILTER_CYCLES,
  parameter int POS_W = 32,
  parameter int TALLY_W = 16
)(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic capture_in,
  input wire logic edge_rise,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_mode,
  input wire logic [POS_W-1:0] motor_position,
  output logic [1:0] mode,
  output logic level,
  output logic cap_pulse,
  output logic [POS_W-1:0] latched_position,
  output logic [TALLY_W-1:0] event_tally
);

  localparam int CNT_W = $clog2(FILTER_CYCLES + 1);

  logic sync1;
  logic sync2;
  logic [CNT_W-1:0] stable_cnt;
  logic hit;
  logic qual;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      sync1 <= 1'h0;
      sync2 <= 1'h0;
    end
    else
    begin
      sync1 <= capture_in;
      sync2 <= sync1;
    end
  end

  // new level must hold for the filter time
  assign hit = (sync2 != level) && (stable_cnt == CNT_W'(FILTER_CYCLES - 1));

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      stable_cnt <= '0;
      level <= 1'h0;
    end
    else if (sync2 == level)
      stable_cnt <= '0;
    else if (hit)
    begin
      level <= sync2;
      stable_cnt <= '0;
    end
    else
      stable_cnt <= CNT_W'(stable_cnt + 1'b1);
  end

  assign qual = hit && (sync2 == edge_rise);

  // command sets mode; once ends itself; zero cancels
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      mode <= fpc_pkg::ARM_STOP;
    else if (cmd_valid)
      mode <= cmd_mode;
    else if (qual && mode == fpc_pkg::ARM_ONCE)
      mode <= fpc_pkg::ARM_STOP;
  end

  // latch position; overwrite each edge; count, clear on arm
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      cap_pulse <= 1'h0;
      latched_position <= POS_W'(fpc_pkg::POS_RESET);
      event_tally <= TALLY_W'(fpc_pkg::TALLY_RESET);
    end
    else
    begin
      cap_pulse <= 1'h0;
      if (cmd_valid)
      begin
        // Only arming clears the tally; a cancel leaves the count readable
        if (cmd_mode != fpc_pkg::ARM_STOP)
          event_tally <= TALLY_W'(fpc_pkg::TALLY_RESET);
      end
      else if (qual && mode != fpc_pkg::ARM_STOP)
      begin
        latched_position <= motor_position;
        event_tally <= TALLY_W'(event_tally + 1'b1);
        cap_pulse <= 1'h1;
      end
    end
  end

  a_filter_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $changed(level) |-> $past(stable_cnt) == CNT_W'(FILTER_CYCLES - 1))
    else $error("Filtered level changed before the filter time");

  a_sync_depth: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $changed(level) |-> $past(capture_in, 3) == level)
    else $error("Filtered level does not follow the synchronised input");

endmodule // fpc_channel

//--- logic/fpc_top.sv
// Fast position capture unit with two channels behind the parameter port.
// Assumes single-cycle parameter reads and writes from the fieldbus side.
`timescale 1ns/10ps
module fpc_top #(
  parameter int FILTER_CYCLES = fpc_pkg::FILTER_CYCLES
)(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic capture_input_a,
  input wire logic capture_input_b,
  input wire logic signed [31:0] motor_position,
  input wire logic [15:0] par_addr,
  input wire logic par_wr,
  input wire logic par_rd,
  input wire logic [31:0] par_wdata,
  output logic [31:0] par_rdata,
  output logic par_rvalid
);

  logic channel_a_edge_setting;
  logic channel_b_edge_setting;
  logic cmd_a;
  logic cmd_b;
  logic [1:0] mode_a;
  logic [1:0] mode_b;
  logic level_a;
  logic level_b;
  logic cap_pulse_a;
  logic cap_pulse_b;
  logic [31:0] pos_a;
  logic [31:0] pos_b;
  logic [15:0] tally_a;
  logic [15:0] tally_b;

  // Values outside the documented set are dropped, the register keeps its value
  function automatic logic arm_ok(input logic [31:0] wdata);
    arm_ok = wdata[15:0] <= fpc_pkg::ARM_MAX;
  endfunction

  function automatic logic edge_ok(input logic [31:0] wdata);
    edge_ok = wdata[15:1] == 15'h0000;
  endfunction

  assign cmd_a = par_wr && par_addr == fpc_pkg::ADDR_A_ARM && arm_ok(par_wdata);
  assign cmd_b = par_wr && par_addr == fpc_pkg::ADDR_B_ARM && arm_ok(par_wdata);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      channel_a_edge_setting <= fpc_pkg::EDGE_RESET;
      channel_b_edge_setting <= fpc_pkg::EDGE_RESET;
    end
    else if (par_wr && edge_ok(par_wdata))
    begin
      if (par_addr == fpc_pkg::ADDR_A_EDGE)
        channel_a_edge_setting <= par_wdata[0];
      if (par_addr == fpc_pkg::ADDR_B_EDGE)
        channel_b_edge_setting <= par_wdata[0];
    end
  end

  fpc_channel #(
    .FILTER_CYCLES(FILTER_CYCLES),
    .POS_W(32),
    .TALLY_W(16)
  ) u_chan_a (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .capture_in(capture_input_a),
    .edge_rise(channel_a_edge_setting),
    .cmd_valid(cmd_a),
    .cmd_mode(par_wdata[1:0]),
    .motor_position(motor_position),
    .mode(mode_a),
    .level(level_a),
    .cap_pulse(cap_pulse_a),
    .latched_position(pos_a),
    .event_tally(tally_a)
  );

  fpc_channel #(
    .FILTER_CYCLES(FILTER_CYCLES),
    .POS_W(32),
    .TALLY_W(16)
  ) u_chan_b (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .capture_in(capture_input_b),
    .edge_rise(channel_b_edge_setting),
    .cmd_valid(cmd_b),
    .cmd_mode(par_wdata[1:0]),
    .motor_position(motor_position),
    .mode(mode_b),
    .level(level_b),
    .cap_pulse(cap_pulse_b),
    .latched_position(pos_b),
    .event_tally(tally_b)
  );

  // read-only views; unmapped addresses read zero
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      par_rvalid <= 1'h0;
      par_rdata <= 32'h0000_0000;
    end
    else
    begin
      par_rvalid <= par_rd;
      if (par_rd)
      begin
        case (par_addr)
          fpc_pkg::ADDR_A_EDGE: par_rdata <= {31'h0000_0000, channel_a_edge_setting};
          fpc_pkg::ADDR_B_EDGE: par_rdata <= {31'h0000_0000, channel_b_edge_setting};
          fpc_pkg::ADDR_A_ARM: par_rdata <= {30'h0000_0000, mode_a};
          fpc_pkg::ADDR_B_ARM: par_rdata <= {30'h0000_0000, mode_b};
          fpc_pkg::ADDR_A_POS: par_rdata <= pos_a;
          fpc_pkg::ADDR_B_POS: par_rdata <= pos_b;
          fpc_pkg::ADDR_A_TALLY: par_rdata <= {16'h0000, tally_a};
          fpc_pkg::ADDR_B_TALLY: par_rdata <= {16'h0000, tally_b};
          default: par_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_once_disarms: assert property (
    cap_pulse_a && $past(mode_a) == fpc_pkg::ARM_ONCE && !$past(cmd_a) |-> mode_a == fpc_pkg::ARM_STOP)
    else $error("Single capture stayed armed after its edge");

  a_cont_rearms: assert property (
    cap_pulse_a && $past(mode_a) == fpc_pkg::ARM_CONT && !$past(cmd_a) |-> mode_a == fpc_pkg::ARM_CONT)
    else $error("Continuous capture dropped out after an edge");

  a_cont_rearms_b: assert property (
    cap_pulse_b && $past(mode_b) == fpc_pkg::ARM_CONT && !$past(cmd_b) |-> mode_b == fpc_pkg::ARM_CONT)
    else $error("Continuous capture on channel b dropped out after an edge");

  a_pos_latched: assert property (
    cap_pulse_a |-> pos_a == $past(motor_position))
    else $error("Channel a did not latch the position of the edge cycle");

  a_pos_latched_b: assert property (
    cap_pulse_b |-> pos_b == $past(motor_position))
    else $error("Channel b did not latch the position of the edge cycle");

  a_tally_steps: assert property (
    cap_pulse_a |-> tally_a == 16'($past(tally_a) + 16'h0001))
    else $error("Event tally did not advance by one");

  a_tally_steps_b: assert property (
    cap_pulse_b |-> tally_b == 16'($past(tally_b) + 16'h0001))
    else $error("Event tally of channel b did not advance by one");

  a_arm_clears: assert property (
    cmd_a && par_wdata[1:0] != 2'h0 |=> tally_a == 16'h0000 && mode_a == $past(par_wdata[1:0]))
    else $error("Arm command did not set mode and clear the tally");

  a_arm_clears_b: assert property (
    cmd_b && par_wdata[1:0] != 2'h0 |=> tally_b == 16'h0000 && mode_b == $past(par_wdata[1:0]))
    else $error("Arm command did not set mode and clear the tally of channel b");

  a_bad_arm_ignored: assert property (
    par_wr && par_addr == fpc_pkg::ADDR_A_ARM && par_wdata[15:0] > fpc_pkg::ARM_MAX
    |=> mode_a == $past(mode_a) || (cap_pulse_a && mode_a == fpc_pkg::ARM_STOP))
    else $error("Undefined arm value was accepted");

  a_cancel_stops: assert property (
    cmd_a && par_wdata[1:0] == 2'h0 |=> mode_a == fpc_pkg::ARM_STOP && !cap_pulse_a && tally_a == $past(tally_a))
    else $error("Cancel did not stop channel a");

  a_cancel_keeps_b: assert property (
    cmd_b && par_wdata[1:0] == 2'h0 |=> mode_b == fpc_pkg::ARM_STOP && tally_b == $past(tally_b))
    else $error("Cancel did not stop channel b or disturbed its tally");

  a_idle_quiet: assert property (
    mode_b == fpc_pkg::ARM_STOP && !cmd_b |=> !cap_pulse_b)
    else $error("Stopped channel b produced a capture");

  a_edge_select: assert property (
    cap_pulse_a |-> level_a == $past(channel_a_edge_setting))
    else $error("Capture on the wrong edge direction");

  a_edge_select_b: assert property (
    cap_pulse_b |-> level_b == $past(channel_b_edge_setting))
    else $error("Capture on channel b on the wrong edge direction");

  a_tally_read: assert property (
    par_rd && par_addr == fpc_pkg::ADDR_A_TALLY |=> par_rvalid && par_rdata == {16'h0000, $past(tally_a)})
    else $error("Tally read back wrong");

  a_pos_read: assert property (
    par_rd && par_addr == fpc_pkg::ADDR_B_POS |=> par_rvalid && par_rdata == $past(pos_b))
    else $error("Position read back wrong");

  c_once_capture: cover property (cap_pulse_a && $past(mode_a) == fpc_pkg::ARM_ONCE);
  c_cont_twice: cover property (cap_pulse_a && mode_a == fpc_pkg::ARM_CONT ##[1:1000] cap_pulse_a);
  c_cancel_armed: cover property (mode_b == fpc_pkg::ARM_ONCE ##1 cmd_b && par_wdata[1:0] == 2'h0);
  c_both_channels: cover property (cap_pulse_a && cap_pulse_b);

endmodule // fpc_top

//--- verification/fpc_trigger_model.sv
// Trigger source model for both capture inputs.
// Assumes the bench requests levels; pins move 1 ns after the clock edge.
`timescale 1ns/10ps
module fpc_trigger_model (
  input wire logic ref_clk,
  input wire logic want_a,
  input wire logic want_b,
  output logic capture_input_a,
  output logic capture_input_b
);
  initial
  begin
    capture_input_a = 1'b0;
    capture_input_b = 1'b0;
  end
  // Skewed off the edge, since real triggers have no relation to the clock
  always @(posedge ref_clk)
  begin
    capture_input_a <= #1 want_a;
    capture_input_b <= #1 want_b;
  end
endmodule // fpc_trigger_model

//--- verification/testbench.sv
// Self-checking bench for the fast position capture unit.
// Assumes fpc_top with a short filter and the trigger model on its inputs.
`timescale 1ns/10ps
module testbench;
  localparam int FC = 4;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic want_a = 1'b0;
  logic want_b = 1'b0;
  logic capture_input_a;
  logic capture_input_b;
  logic signed [31:0] motor_position = 32'h0000_0000;
  logic [15:0] par_addr = 16'h0000;
  logic par_wr = 1'b0;
  logic par_rd = 1'b0;
  logic [31:0] par_wdata = 32'h0000_0000;
  logic [31:0] par_rdata;
  logic par_rvalid;
  int mismatches = 0;
  int check_count = 0;
  integer seed = 79963;
  logic [31:0] pos_a;
  logic [31:0] pos_b;
  logic [15:0] d;
  logic [15:0] exp_arm;

  always #2 ref_clk = ~ref_clk;

  fpc_top #(.FILTER_CYCLES(FC)) i_fpc_top (.ref_clk(ref_clk), .rst_b(rst_b), .capture_input_a(capture_input_a),
    .capture_input_b(capture_input_b), .motor_position(motor_position), .par_addr(par_addr), .par_wr(par_wr),
    .par_rd(par_rd), .par_wdata(par_wdata), .par_rdata(par_rdata), .par_rvalid(par_rvalid));
  fpc_trigger_model i_fpc_trigger_model (.ref_clk(ref_clk), .want_a(want_a), .want_b(want_b),
    .capture_input_a(capture_input_a), .capture_input_b(capture_input_b));

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    par_addr = a;
    par_wdata = {16'h0000, v};
    par_wr = 1'b1;
    tick(1);
    par_wr = 1'b0;
    // Let an edge pass so back-to-back writes stay distinct strobes
    tick(1);
  endtask

  // Answer is due exactly one cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
    par_addr = a;
    par_rd = 1'b1;
    tick(1);
    par_rd = 1'b0;
    compare({what, " valid"}, 32'h1, {31'h0, par_rvalid});
    compare(what, exp, par_rdata);
    tick(1);
  endtask

  // Full pulse on one input with the position held still around both edges
  task automatic pulse(input bit on_b, input logic [31:0] p);
    motor_position = p;
    if (on_b) want_b = 1'b1; else want_a = 1'b1;
    tick(FC + 8);
    if (on_b) want_b = 1'b0; else want_a = 1'b0;
    tick(FC + 8);
    motor_position = $random(seed);
  endtask

  // Codes above two are dropped, so the old mode stays
  function automatic logic [15:0] arm_next(input logic [15:0] v, input logic [15:0] prev);
    return (v > 16'h0002) ? prev : v;
  endfunction

  task automatic final_report();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    mismatches++;
    final_report();
  end

  initial
  begin
    tick(3);
    rst_b = 1'b1;
    rd(fpc_pkg::ADDR_A_EDGE, 32'h0, "edge a");
    rd(fpc_pkg::ADDR_A_ARM, 32'h0, "arm a");
    rd(fpc_pkg::ADDR_B_POS, 32'h0, "pos b");
    rd(fpc_pkg::ADDR_A_TALLY, 32'h0, "tally a");
    rd(16'h0a20, 32'h0, "unmapped");
    $display("test reset done");
    exp_arm = 16'h0000;
    for (int i = 0; i < 6; i++)
    begin
      d = (i == 0) ? 16'h0003 : 16'($random(seed) & 16'h0007);
      exp_arm = arm_next(d, exp_arm);
      wr(fpc_pkg::ADDR_A_ARM, d);
      rd(fpc_pkg::ADDR_A_ARM, {16'h0, exp_arm}, "arm a code");
    end
    wr(fpc_pkg::ADDR_A_ARM, 16'h0000);
    wr(fpc_pkg::ADDR_A_EDGE, 16'h0003);
    rd(fpc_pkg::ADDR_A_EDGE, 32'h0, "edge a bad");
    $display("test codes done");
    wr(fpc_pkg::ADDR_A_ARM, 16'h0001);
    pos_a = $random(seed);
    pulse(1'b0, pos_a);
    rd(fpc_pkg::ADDR_A_POS, pos_a, "pos a");
    rd(fpc_pkg::ADDR_A_TALLY, 32'h1, "tally a");
    rd(fpc_pkg::ADDR_A_ARM, 32'h0, "arm a done");
    pulse(1'b0, $random(seed));
    rd(fpc_pkg::ADDR_A_POS, pos_a, "pos a kept");
    wr(fpc_pkg::ADDR_A_POS, 16'h1234);
    rd(fpc_pkg::ADDR_A_POS, pos_a, "pos a read only");
    wr(fpc_pkg::ADDR_A_TALLY, 16'h0005);
    rd(fpc_pkg::ADDR_A_TALLY, 32'h1, "tally a read only");
    $display("test single done");
    wr(fpc_pkg::ADDR_B_EDGE, 16'h0001);
    wr(fpc_pkg::ADDR_B_ARM, 16'h0002);
    for (int i = 1; i <= 3; i++)
    begin
      pos_b = $random(seed);
      pulse(1'b1, pos_b);
      rd(fpc_pkg::ADDR_B_POS, pos_b, "pos b");
      rd(fpc_pkg::ADDR_B_TALLY, i, "tally b");
    end
    rd(fpc_pkg::ADDR_B_ARM, 32'h2, "arm b");
    rd(fpc_pkg::ADDR_A_POS, pos_a, "pos a alone");
    $display("test continuous done");
    want_b = 1'b1;
    tick(FC - 1);
    want_b = 1'b0;
    tick(FC + 8);
    rd(fpc_pkg::ADDR_B_TALLY, 32'h3, "tally b glitch");
    wr(fpc_pkg::ADDR_B_ARM, 16'h0000);
    pulse(1'b1, $random(seed));
    rd(fpc_pkg::ADDR_B_TALLY, 32'h3, "tally b stopped");
    wr(fpc_pkg::ADDR_B_ARM, 16'h0001);
    rd(fpc_pkg::ADDR_B_TALLY, 32'h0, "tally b rearm");
    wr(fpc_pkg::ADDR_B_ARM, 16'h0000);
    pulse(1'b1, $random(seed));
    rd(fpc_pkg::ADDR_B_TALLY, 32'h0, "tally b once cancelled");
    rd(fpc_pkg::ADDR_B_POS, pos_b, "pos b once cancelled");
    $display("test cancel done");
    final_report();
  end
endmodule // testbench
